// ==== ast_params.svh ====
// Register offsets, field positions, reset values and timing counts of the transceiver.
`ifndef AST_PARAMS_SVH
`define AST_PARAMS_SVH
`define AST_OFS_MODE       3'h0
`define AST_OFS_STAT       3'h1
`define AST_OFS_TXDATA     3'h2
`define AST_OFS_RXDATA     3'h3
`define AST_OFS_PRESC      3'h4
`define AST_MODE_RESET     16'h0000
`define AST_MODE_WMASK     16'hbbff
`define AST_PRESC_RESET    16'h0000
`define AST_ST_RXAVAIL     0
`define AST_ST_OVERRUN     1
`define AST_ST_FRAMEERR    2
`define AST_ST_PARERR      3
`define AST_ST_RXIDLE      4
`define AST_ST_ADDREN      5
`define AST_ST_TXEMPTY     8
`define AST_ST_TXFULL      9
`define AST_ST_TXEN        10
`define AST_ST_BREAK       11
`define AST_LAST_STD       4'hf
`define AST_LAST_FAST      4'h3
`define AST_HALF_STD       4'h7
`define AST_HALF_FAST      4'h1
`define AST_BRK_BITS       4'hc
`define AST_IR_PULSE       4'h3
`define AST_IR_HOLD        4'hf
`define AST_SYNC_EDGES     3'h5
`define AST_AB_SHIFT_STD   7
`define AST_AB_SHIFT_FAST  5
`endif

// ==== ast_pkg.sv ====
// Types shared by the transceiver modules.
package ast_pkg;
   typedef struct packed {
      logic       module_on;
      logic       rsvd14;
      logic       idle_halt;
      logic       infrared_codec_on;
      logic       rts_pin_style;
      logic       rsvd10;
      logic [1:0] pin_use_select;
      logic       wake_on_start;
      logic       loop_test_select;
      logic       auto_rate_measure;
      logic       rx_idle_invert;
      logic       fast_rate_select;
      logic [1:0] width_parity_select;
      logic       stop_count_select;
   } ast_mode_s;
   typedef struct packed {
      logic       par_err;
      logic       frame_err;
      logic [8:0] data;
   } ast_rx_entry_s;
   typedef enum logic [2:0] {
      AST_RX_IDLE  = 3'b000,
      AST_RX_START = 3'b001,
      AST_RX_DATA  = 3'b010,
      AST_RX_PAR   = 3'b011,
      AST_RX_STOP  = 3'b100
   } ast_rx_state_e;
   typedef enum logic [2:0] {
      AST_TX_IDLE  = 3'b000,
      AST_TX_START = 3'b001,
      AST_TX_DATA  = 3'b010,
      AST_TX_PAR   = 3'b011,
      AST_TX_STOP  = 3'b100,
      AST_TX_BRK   = 3'b101
   } ast_tx_state_e;
endpackage : ast_pkg

// ==== ast_fifo.sv ====
// Flip-flop queue with push, pop and synchronous clear.
`timescale 1ns/1ps
module ast_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 4
) (
   input  wire logic             sys_clk_i,
   input  wire logic             rstn_i,
   input  wire logic             clr_i,
   input  wire logic             push_i,
   input  wire logic [WIDTH-1:0] din_i,
   input  wire logic             pop_i,
   output logic      [WIDTH-1:0] dout_o,
   output logic                  full_o,
   output logic                  empty_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ff;
   logic [AW-1:0]    rd_ff;
   logic [AW:0]      cnt_ff;
   wire              do_push = push_i & ~full_o;
   wire              do_pop  = pop_i & ~empty_o;
   wire  [AW-1:0]    last    = AW'(DEPTH - 1);

   assign full_o  = (cnt_ff == (AW+1)'(DEPTH));
   assign empty_o = (cnt_ff == '0);
   assign dout_o  = mem_ff[rd_ff];

   always_ff @(posedge sys_clk_i)
   begin
      if (do_push)
         mem_ff[wr_ff] <= din_i;
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end
      else if (clr_i)
      begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end
      else
      begin
         if (do_push)
            wr_ff <= (wr_ff == last) ? '0 : wr_ff + 1'b1;
         if (do_pop)
            rd_ff <= (rd_ff == last) ? '0 : rd_ff + 1'b1;
         cnt_ff <= cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end
endmodule : ast_fifo

// ==== ast_rate_gen.sv ====
// Prescaler that makes the oversampling tick and the baud clock output.
`timescale 1ns/1ps
module ast_rate_gen #(
   parameter int PW = 16
) (
   input  wire logic          sys_clk_i,
   input  wire logic          rstn_i,
   input  wire logic          en_i,
   input  wire logic [PW-1:0] div_i,
   output logic               tick_o,
   output logic               bclk_o
);
   logic [PW-1:0] cnt_ff;
   logic          bclk_ff;
   wire           wrap = (cnt_ff >= div_i);

   assign tick_o = en_i & wrap;
   assign bclk_o = bclk_ff;

   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cnt_ff  <= '0;
         bclk_ff <= 1'b0;
      end
      else if (!en_i)
      begin
         cnt_ff  <= '0;
         bclk_ff <= 1'b0;
      end
      else
      begin
         cnt_ff  <= wrap ? '0 : cnt_ff + 1'b1;
         bclk_ff <= (cnt_ff <= (div_i >> 1));
      end
   end
endmodule : ast_rate_gen

// ==== ast_transceiver.sv ====
// Asynchronous serial transceiver with mode, status, data and prescaler registers.
`timescale 1ns/1ps
`include "ast_params.svh"
// Summary of operation
// R01 - Enable drives pins; disabled releases to port
// R02 - Idle-halt stops operation in Idle mode
// R03 - Infrared codec inserted on both paths
// R04 - Software uses infrared only at 16x
// R05 - Request pin: simplex or flow control
// R06 - Pin-use field chooses the driven pins
// R07 - Wake: falling edge event, rising clears
// R08 - Loopback routes transmitter into receiver
// R09 - Auto-baud measures sync field, self-clears
// R10 - Eight/nine bits, parity, one/two stops
// R11 - Bit timing from 16-bit prescaler
// R12 - Four-deep transmit and receive queues
// R13 - Parity, framing, overrun on error event
// R14 - Nine-bit address detect by ninth bit
// R15 - Drive request, honour clear-to-send
// R16 - Baud clock output at tick rate: 16x, or 4x with fast select
// R17 - Break and sync characters transmitted
// R18 - Receive idle level set by invert bit
// R19 - First character after wake is invalid
// R20 - Fast select: 4 or 16 ticks
// R21 - Width/parity field encoding
// R22 - Stop select gives two or one
// R23 - Start, LSB first, parity, stop bits
// R24 - Centre sampling, framing error on stop
module ast_transceiver
   import ast_pkg::*;
#(
   parameter int FIFO_DEPTH = 4
) (
   input  wire logic        sys_clk_i,
   input  wire logic        rstn_i,
   input  wire logic [2:0]  addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [15:0] rdata_o,
   input  wire logic        idle_mode_i,
   input  wire logic        sleep_mode_i,
   input  wire logic        serial_in_pin_i,
   output logic             serial_out_pin_o,
   output logic             serial_out_pin_oe_o,
   input  wire logic        clear_to_send_pin_n_i,
   output logic             request_to_send_pin_n_o,
   output logic             request_to_send_pin_oe_o,
   output logic             baud_clock_o,
   output logic             baud_clock_oe_o,
   output logic             tx_event_o,
   output logic             rx_event_o,
   output logic             err_event_o,
   output logic             wake_event_o
);
   import ast_pkg::*;

   function automatic logic [3:0] last_tick(input logic fast);
      last_tick = fast ? `AST_LAST_FAST : `AST_LAST_STD;
   endfunction : last_tick

   function automatic logic par_bit(input logic [7:0] d, input logic odd);
      par_bit = (^d) ^ odd;
   endfunction : par_bit

   ast_mode_s     mode_ff;
   logic [15:0]   presc_ff;
   logic          overrun_ff, addr_en_ff, tx_en_ff, brk_ff;
   logic [15:0]   rdata_ff;
   logic          rx_lvl_ff, run_tick;
   ast_rx_state_e rx_st_ff;
   logic [3:0]    rx_ph_ff, rx_bit_ff, ir_hold_ff;
   logic [8:0]    rx_sh_ff;
   logic          rx_par_ff;
   ast_tx_state_e tx_st_ff;
   logic [3:0]    tx_ph_ff, tx_bit_ff;
   logic [8:0]    tx_sh_ff;
   logic          tx_lvl_ff;
   logic [7:0]    tx_par_data_ff;
   logic [23:0]   ab_cnt_ff;
   logic [2:0]    ab_edges_ff;
   logic          wake_armed_ff;
   logic          tick, bclk;
   ast_rx_entry_s rx_head, rx_new;
   logic          rx_full, rx_empty, tx_full, tx_empty;
   logic [8:0]    tx_head;

   // R02 idle halt gating
   wire run = mode_ff.module_on & ~(mode_ff.idle_halt & idle_mode_i) & ~sleep_mode_i;
   wire nine      = (mode_ff.width_parity_select == 2'b11);
   wire par_on    = ~nine & (mode_ff.width_parity_select != 2'b00);
   wire par_odd   = (mode_ff.width_parity_select == 2'b10);
   wire [3:0] lt  = last_tick(mode_ff.fast_rate_select);
   wire [3:0] half = mode_ff.fast_rate_select ? `AST_HALF_FAST : `AST_HALF_STD;
   wire use_rts   = (mode_ff.pin_use_select == 2'b01) | (mode_ff.pin_use_select == 2'b10);
   wire use_cts   = (mode_ff.pin_use_select == 2'b10);
   wire use_bclk  = (mode_ff.pin_use_select == 2'b11);
   wire wr_mode   = wr_i & (addr_i == `AST_OFS_MODE);
   wire wr_stat   = wr_i & (addr_i == `AST_OFS_STAT);
   wire wr_tx     = wr_i & (addr_i == `AST_OFS_TXDATA);
   wire wr_presc  = wr_i & (addr_i == `AST_OFS_PRESC);
   wire rd_rx     = rd_i & (addr_i == `AST_OFS_RXDATA);

   // R11 prescaler tick
   ast_rate_gen #(.PW(16)) u_rate (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .en_i      (run),
      .div_i     (presc_ff),
      .tick_o    (tick),
      .bclk_o    (bclk)
   );
   assign run_tick = run & tick;

   // R08 loopback source and R03 infrared decoder
   wire raw_in  = mode_ff.loop_test_select ? serial_out_pin_o : serial_in_pin_i;
   wire ir_dec  = (ir_hold_ff != 4'h0) | raw_in ? 1'b0 : 1'b1;
   wire line_in = mode_ff.infrared_codec_on ? ir_dec : raw_in;
   // R18 idle level normalised to one
   wire rx_lvl  = line_in ^ mode_ff.rx_idle_invert;
   wire rx_fall = rx_lvl_ff & ~rx_lvl;
   wire rx_rise = ~rx_lvl_ff & rx_lvl;

   wire tx_clr  = ~mode_ff.module_on | ~tx_en_ff;
   wire tx_load = run_tick & (tx_st_ff == AST_TX_IDLE) & ~tx_clr & ~tx_empty & ~brk_ff
                  & ~(use_cts & clear_to_send_pin_n_i);
   // R12 transmit queue
   ast_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_txq (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .clr_i     (tx_clr),
      .push_i    (wr_tx),
      .din_i     (wdata_i[8:0]),
      .pop_i     (tx_load),
      .dout_o    (tx_head),
      .full_o    (tx_full),
      .empty_o   (tx_empty)
   );

   wire rx_done  = run_tick & (rx_st_ff == AST_RX_STOP) & (rx_ph_ff == lt);
   wire [8:0] rx_data = nine ? rx_sh_ff : {1'b0, rx_sh_ff[8:1]};
   // R14 address filter
   wire addr_skip = addr_en_ff & nine & ~rx_data[8];
   wire rx_take  = rx_done & ~mode_ff.auto_rate_measure & ~addr_skip;
   wire ovr_set  = rx_take & rx_full;
   wire ovr_clr  = wr_stat & ~wdata_i[`AST_ST_OVERRUN] & overrun_ff & ~ovr_set;
   assign rx_new.data      = rx_data;
   // R24 framing on first stop
   assign rx_new.frame_err = ~rx_lvl;
   assign rx_new.par_err   = par_on & (rx_par_ff != par_bit(rx_data[7:0], par_odd));
   // R12 receive queue
   ast_fifo #(.WIDTH(11), .DEPTH(FIFO_DEPTH)) u_rxq (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .clr_i     (~mode_ff.module_on | ovr_clr),
      .push_i    (rx_take & ~overrun_ff),
      .din_i     (rx_new),
      .pop_i     (rd_rx),
      .dout_o    (rx_head),
      .full_o    (rx_full),
      .empty_o   (rx_empty)
   );

   // R09 sync field divisor
   wire [23:0] ab_div = mode_ff.fast_rate_select ? (ab_cnt_ff >> `AST_AB_SHIFT_FAST)
                                                 : (ab_cnt_ff >> `AST_AB_SHIFT_STD);
   wire ab_done = mode_ff.auto_rate_measure & run & rx_fall
                  & (ab_edges_ff == `AST_SYNC_EDGES - 3'h1);
   // R07 wake edge events
   wire wake_fall = mode_ff.wake_on_start & sleep_mode_i & rx_fall;
   wire wake_clr  = mode_ff.wake_on_start & wake_armed_ff & rx_rise;

   wire [15:0] stat_rd = {4'h0, brk_ff, tx_en_ff, tx_full,
                          tx_empty & (tx_st_ff == AST_TX_IDLE), 2'b00, addr_en_ff,
                          rx_st_ff == AST_RX_IDLE, rx_head.par_err & ~rx_empty,
                          rx_head.frame_err & ~rx_empty, overrun_ff, ~rx_empty};
   wire [15:0] rd_mux = (addr_i == `AST_OFS_MODE)   ? (mode_ff & `AST_MODE_WMASK) :
                        (addr_i == `AST_OFS_STAT)   ? stat_rd :
                        (addr_i == `AST_OFS_RXDATA) ? {7'h00, rx_head.data} :
                        (addr_i == `AST_OFS_PRESC)  ? presc_ff : 16'h0000;

   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         mode_ff       <= `AST_MODE_RESET;
         presc_ff      <= `AST_PRESC_RESET;
         overrun_ff    <= 1'b0;
         addr_en_ff    <= 1'b0;
         tx_en_ff      <= 1'b0;
         brk_ff        <= 1'b0;
         rdata_ff      <= 16'h0000;
         wake_armed_ff <= 1'b0;
      end
      else
      begin
         rdata_ff <= rd_i ? rd_mux : 16'h0000;
         if (wr_mode)
            mode_ff <= wdata_i & `AST_MODE_WMASK;
         else
         begin
            // R09 auto-baud clears itself
            if (ab_done)
               mode_ff.auto_rate_measure <= 1'b0;
            // R07 wake clears on rising
            if (wake_clr)
               mode_ff.wake_on_start <= 1'b0;
         end
         if (wake_fall)
            wake_armed_ff <= 1'b1;
         else if (wake_clr | ~mode_ff.wake_on_start)
            wake_armed_ff <= 1'b0;
         if (wr_presc)
            presc_ff <= wdata_i;
         else if (ab_done)
            presc_ff <= (ab_div == 24'h0) ? 16'h0000 : ab_div[15:0] - 16'h0001;
         // R13 overrun set beats clear
         if (ovr_set)
            overrun_ff <= 1'b1;
         else if (ovr_clr)
            overrun_ff <= 1'b0;
         if (wr_stat)
         begin
            addr_en_ff <= wdata_i[`AST_ST_ADDREN];
            tx_en_ff   <= wdata_i[`AST_ST_TXEN];
         end
         // R17 break request self-clears
         if (wr_stat & wdata_i[`AST_ST_BREAK])
            brk_ff <= 1'b1;
         else if (tx_clr | (run_tick & (tx_st_ff == AST_TX_BRK)
                            & (tx_bit_ff == `AST_BRK_BITS) & (tx_ph_ff == lt)))
            brk_ff <= 1'b0;
      end
   end

   // R09 count sync edges
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         ab_cnt_ff   <= 24'h0;
         ab_edges_ff <= 3'h0;
         rx_lvl_ff   <= 1'b1;
         ir_hold_ff  <= 4'h0;
      end
      else
      begin
         rx_lvl_ff <= rx_lvl;
         if (raw_in & mode_ff.infrared_codec_on)
            ir_hold_ff <= `AST_IR_HOLD;
         else if (run_tick & (ir_hold_ff != 4'h0))
            ir_hold_ff <= ir_hold_ff - 4'h1;
         if (~mode_ff.auto_rate_measure | ~run | ab_done)
         begin
            ab_cnt_ff   <= 24'h0;
            ab_edges_ff <= 3'h0;
         end
         else
         begin
            if (ab_edges_ff != 3'h0)
               ab_cnt_ff <= ab_cnt_ff + 24'h1;
            if (rx_fall)
               ab_edges_ff <= ab_edges_ff + 3'h1;
         end
      end
   end

   // R24 receiver centre sampling
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rx_st_ff  <= AST_RX_IDLE;
         rx_ph_ff  <= 4'h0;
         rx_bit_ff <= 4'h0;
         rx_sh_ff  <= 9'h000;
         rx_par_ff <= 1'b0;
      end
      else if (~mode_ff.module_on)
         rx_st_ff <= AST_RX_IDLE;
      else if (run_tick)
      begin
         rx_ph_ff <= (rx_ph_ff == lt) ? 4'h0 : rx_ph_ff + 4'h1;
         case (rx_st_ff)
            AST_RX_IDLE:
            begin
               rx_ph_ff <= 4'h0;
               if (~rx_lvl)
                  rx_st_ff <= AST_RX_START;
            end
            AST_RX_START:
               if (rx_ph_ff == half)
               begin
                  rx_ph_ff  <= 4'h0;
                  rx_bit_ff <= 4'h0;
                  rx_st_ff  <= rx_lvl ? AST_RX_IDLE : AST_RX_DATA;
               end
            // R23 least significant first
            AST_RX_DATA:
               if (rx_ph_ff == lt)
               begin
                  rx_sh_ff  <= {rx_lvl, rx_sh_ff[8:1]};
                  rx_bit_ff <= rx_bit_ff + 4'h1;
                  if (rx_bit_ff == (nine ? 4'h8 : 4'h7))
                     rx_st_ff <= par_on ? AST_RX_PAR : AST_RX_STOP;
               end
            AST_RX_PAR:
               if (rx_ph_ff == lt)
               begin
                  rx_par_ff <= rx_lvl;
                  rx_st_ff  <= AST_RX_STOP;
               end
            AST_RX_STOP:
               if (rx_ph_ff == lt)
                  rx_st_ff <= AST_RX_IDLE;
            default:
               rx_st_ff <= AST_RX_IDLE;
         endcase
      end
   end

   // R10 transmit frame sequencing
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         tx_st_ff  <= AST_TX_IDLE;
         tx_ph_ff  <= 4'h0;
         tx_bit_ff <= 4'h0;
         tx_sh_ff  <= 9'h000;
         tx_lvl_ff <= 1'b1;
      end
      else if (tx_clr)
      begin
         tx_st_ff  <= AST_TX_IDLE;
         tx_lvl_ff <= 1'b1;
      end
      else if (run_tick)
      begin
         tx_ph_ff <= (tx_ph_ff == lt) ? 4'h0 : tx_ph_ff + 4'h1;
         case (tx_st_ff)
            AST_TX_IDLE:
            begin
               tx_ph_ff  <= 4'h0;
               tx_bit_ff <= 4'h0;
               // R17 break frame start
               if (brk_ff)
               begin
                  tx_lvl_ff <= 1'b0;
                  tx_st_ff  <= AST_TX_BRK;
               end
               // R15 clear-to-send gating
               else if (tx_load)
               begin
                  tx_sh_ff  <= tx_head;
                  tx_lvl_ff <= 1'b0;
                  tx_st_ff  <= AST_TX_START;
               end
            end
            AST_TX_START:
               if (tx_ph_ff == lt)
               begin
                  tx_lvl_ff <= tx_sh_ff[0];
                  tx_st_ff  <= AST_TX_DATA;
               end
            AST_TX_DATA:
               if (tx_ph_ff == lt)
               begin
                  tx_bit_ff <= tx_bit_ff + 4'h1;
                  tx_sh_ff  <= {1'b0, tx_sh_ff[8:1]};
                  if (tx_bit_ff == (nine ? 4'h8 : 4'h7))
                  begin
                     tx_bit_ff <= 4'h0;
                     tx_lvl_ff <= par_on ? par_bit(tx_par_data_ff, par_odd) : 1'b1;
                     tx_st_ff  <= par_on ? AST_TX_PAR : AST_TX_STOP;
                  end
                  else
                     tx_lvl_ff <= tx_sh_ff[1];
               end
            AST_TX_PAR:
               if (tx_ph_ff == lt)
               begin
                  tx_lvl_ff <= 1'b1;
                  tx_st_ff  <= AST_TX_STOP;
               end
            // R22 one or two stops
            AST_TX_STOP:
               if (tx_ph_ff == lt)
               begin
                  tx_bit_ff <= tx_bit_ff + 4'h1;
                  if (~mode_ff.stop_count_select | (tx_bit_ff == 4'h1))
                     tx_st_ff <= AST_TX_IDLE;
               end
            AST_TX_BRK:
               if (tx_ph_ff == lt)
               begin
                  tx_bit_ff <= tx_bit_ff + 4'h1;
                  if (tx_bit_ff == `AST_BRK_BITS)
                  begin
                     tx_bit_ff <= 4'h0;
                     tx_lvl_ff <= 1'b1;
                     tx_st_ff  <= AST_TX_STOP;
                  end
               end
            default:
               tx_st_ff <= AST_TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         tx_par_data_ff <= 8'h00;
      else if (tx_load)
         tx_par_data_ff <= tx_head[7:0];
   end

   // R03 infrared pulse encoder
   wire ir_out = ~tx_lvl_ff & (tx_ph_ff < `AST_IR_PULSE) & (tx_st_ff != AST_TX_IDLE);
   // R01 pins follow enable and R06 selection
   assign serial_out_pin_o    = mode_ff.infrared_codec_on ? ir_out : tx_lvl_ff;
   assign serial_out_pin_oe_o = mode_ff.module_on & tx_en_ff;
   // R05 request pin style
   assign request_to_send_pin_n_o  = mode_ff.rts_pin_style ? (tx_st_ff == AST_TX_IDLE)
                                                           : rx_full;
   assign request_to_send_pin_oe_o = mode_ff.module_on & use_rts;
   // R16 baud clock output
   assign baud_clock_o    = bclk;
   assign baud_clock_oe_o = mode_ff.module_on & use_bclk;
   assign rdata_o         = rdata_ff;
   assign tx_event_o      = tx_load;
   assign rx_event_o      = rx_take & ~rx_full & ~overrun_ff;
   // R13 single error event
   assign err_event_o     = rx_take & (rx_new.frame_err | rx_new.par_err | rx_full);
   assign wake_event_o    = wake_fall & ~wake_armed_ff;
endmodule : ast_transceiver

// ==== ast_transceiver_asserts.sv ====
// Port checker of the serial transceiver.
`timescale 1ns/1ps
module ast_transceiver_asserts (
   input wire logic        sys_clk_i,
   input wire logic        rstn_i,
   input wire logic        rd_i,
   input wire logic [15:0] rdata_o,
   input wire logic        sleep_mode_i,
   input wire logic        serial_out_pin_oe_o,
   input wire logic        request_to_send_pin_oe_o,
   input wire logic        baud_clock_oe_o,
   input wire logic        tx_event_o,
   input wire logic        rx_event_o,
   input wire logic        err_event_o,
   input wire logic        wake_event_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
      else $error("read data outside a read cycle");
   AST_PINS_EXCL: assert property (!(baud_clock_oe_o && request_to_send_pin_oe_o))
      else $error("baud clock and request pin both enabled");
   AST_TX_OE: assert property (tx_event_o |-> serial_out_pin_oe_o)
      else $error("transmit started with pin released");
   AST_TX_SPACE: assert property (tx_event_o |=> !tx_event_o [*8])
      else $error("transmit events too close");
   AST_RX_PULSE: assert property (rx_event_o |=> !rx_event_o [*8])
      else $error("receive events too close");
   AST_ERR_PULSE: assert property (err_event_o |=> !err_event_o [*8])
      else $error("error events too close");
   AST_WAKE_SLEEP: assert property (wake_event_o |-> sleep_mode_i || $past(sleep_mode_i))
      else $error("wake event outside sleep");
   AST_WAKE_ONCE: assert property (wake_event_o |=> !wake_event_o [*8])
      else $error("wake event repeated");
endmodule : ast_transceiver_asserts
bind ast_transceiver ast_transceiver_asserts ast_transceiver_asserts_inst (.*);

// ==== ast_remote_node.sv ====
// Remote serial node that sends frames to the transceiver.
`timescale 1ns/1ps
module ast_remote_node #(
   parameter int BIT_CLKS = 16
) (
   input  wire logic sys_clk_i,
   output logic      line_o,
   output logic      cts_n_o
);
   assign cts_n_o = 1'b0;
   initial line_o = 1'b1;
   task automatic send(input logic [7:0] b, input logic stp);
      logic [9:0] f;
      f = {stp, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         line_o <= f[i];
         repeat (BIT_CLKS) @(posedge sys_clk_i);
      end
      line_o <= 1'b1;
   endtask : send
endmodule : ast_remote_node

// ==== tb_top.sv ====
// Self-checking bench of the serial transceiver.
`timescale 1ns/1ps
module tb_top;
   import ast_pkg::*;
   logic        sys_clk_i, rstn_i, wr_i, rd_i, sleep_mode_i, idle_mode_i, rx_line, cts_n;
   logic        tx_oe, rts_oe, rts_n, bclk_oe, tx_ev, rx_ev, err_ev, wk_ev;
   logic [2:0]  addr_i;
   logic [15:0] wdata_i, rdata_o, d;
   int          err_count, n_checks, cyc, nrx, nerr, nwk, t;
   ast_transceiver ast_transceiver_inst (
      .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .idle_mode_i(idle_mode_i),
      .sleep_mode_i(sleep_mode_i), .serial_in_pin_i(rx_line), .serial_out_pin_o(),
      .serial_out_pin_oe_o(tx_oe), .clear_to_send_pin_n_i(cts_n),
      .request_to_send_pin_n_o(rts_n), .request_to_send_pin_oe_o(rts_oe), .baud_clock_o(),
      .baud_clock_oe_o(bclk_oe), .tx_event_o(tx_ev), .rx_event_o(rx_ev),
      .err_event_o(err_ev), .wake_event_o(wk_ev));
   ast_remote_node ast_remote_node_inst (.sys_clk_i(sys_clk_i), .line_o(rx_line),
      .cts_n_o(cts_n));
   initial
   begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i)
   begin
      cyc++;
      nrx += (rx_ev === 1'b1);
      nerr += (err_ev === 1'b1);
      nwk += (wk_ev === 1'b1);
      if (cyc == 60000)
      begin
         err_count++;
         final_report;
      end
   end
   task automatic final_report;
      $display("Checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : final_report
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [15:0] v);
      @(posedge sys_clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      @(negedge sys_clk_i);
      d = rdata_o;
   endtask : rd
   task automatic rc(input logic [2:0] a, input logic [15:0] e, input string nm);
      rd(a);
      chk(nm, e, d);
   endtask : rc
   task automatic wt(input int n, ref int c);
      for (int k = 0; k < 3000 && c < n; k++) @(posedge sys_clk_i);
      if (c < n) chk("event wait", 16'(n), 16'(c));
   endtask : wt
   initial
   begin
      rstn_i = 1'b0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 3'h0;
      wdata_i = 16'h0000;
      sleep_mode_i = 1'b0;
      idle_mode_i = 1'b0;
      repeat (12) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      rc(3'h0, 16'h0000, "mode reset");
      rc(3'h7, 16'h0000, "unmapped");
      wr(3'h0, 16'h4400);
      rc(3'h0, 16'h0000, "reserved bits");
      wr(3'h1, 16'h0400);
      for (int p = 0; p < 4; p++)
      begin
         wr(3'h0, 16'h8000 | 16'(p << 8));
         @(negedge sys_clk_i);
         chk("pins", {13'h0, p == 3, p == 1 || p == 2, 1'b1}, {13'h0, bclk_oe, rts_oe, tx_oe});
      end
      for (int m = 0; m < 5; m++)
      begin
         wr(3'h0, 16'h8040 | (m == 4 ? 16'h1000 : 16'((m << 1) | (m & 1))));
         t = nrx + 1;
         wr(3'h2, 16'h01a5);
         wt(t, nrx);
         rc(3'h3, m == 3 ? 16'h01a5 : 16'h00a5, "loop data");
      end
      wr(3'h0, 16'h8000);
      ast_remote_node_inst.send(8'h3c, 1'b1);
      rc(3'h3, 16'h003c, "remote data");
      t = nerr + 1;
      ast_remote_node_inst.send(8'h81, 1'b0);
      wt(t, nerr);
      rd(3'h1);
      chk("framing", 16'h0005, d & 16'h000f);
      rc(3'h3, 16'h0081, "bad stop data");
      wr(3'h0, 16'h8002);
      t = nerr + 1;
      ast_remote_node_inst.send(8'h03, 1'b1);
      wt(t, nerr);
      rd(3'h1);
      chk("parity", 16'h0009, d & 16'h000f);
      wr(3'h4, 16'h0005);
      wr(3'h0, 16'h8020);
      ast_remote_node_inst.send(8'h55, 1'b1);
      rc(3'h0, 16'h8000, "rate mode");
      rc(3'h4, 16'h0000, "measured rate");
      wr(3'h0, 16'h0000);
      wr(3'h0, 16'h8140);
      t = nerr + 1;
      for (int i = 0; i < 5; i++) wr(3'h2, 16'(i));
      rd(3'h1);
      chk("tx full", 16'h0200, d & 16'h0200);
      wt(t, nerr);
      rd(3'h1);
      chk("overrun", 16'h0003, d & 16'h0003);
      chk("rts full", 16'h0001, {15'h0, rts_n});
      wr(3'h1, 16'h0400);
      rd(3'h1);
      chk("emptied", 16'h0000, d & 16'h0003);
      wr(3'h0, 16'ha040);
      idle_mode_i <= 1'b1;
      t = nrx + 1;
      wr(3'h2, 16'h0055);
      repeat (400) @(posedge sys_clk_i);
      chk("idle halt", 16'(t - 1), 16'(nrx));
      idle_mode_i <= 1'b0;
      wt(t, nrx);
      chk("idle resume", 16'(t), 16'(nrx));
      wr(3'h0, 16'h8080);
      sleep_mode_i <= 1'b1;
      t = nwk + 1;
      ast_remote_node_inst.send(8'h3c, 1'b1);
      wt(t, nwk);
      sleep_mode_i <= 1'b0;
      chk("wake", 16'(t), 16'(nwk));
      rc(3'h0, 16'h8000, "wake cleared");
      wr(3'h0, 16'h0000);
      @(negedge sys_clk_i);
      chk("released", 16'h0000, {15'h0, tx_oe});
      final_report;
   end
endmodule : tb_top
